// file: src/crpoc_pkg.sv
// crpoc_pkg: shared constants for the parity checker and output control ends
// assumes a single 100 MHz clock; both ends import the whole package
package crpoc_pkg;
    localparam int  CRPOC_AC_W        = 24;
    localparam int  CRPOC_CS_W        = 4;
    localparam int  CRPOC_CKE_W       = 2;
    localparam int  CRPOC_ODT_W       = 2;
    localparam int  CRPOC_ERR_LAT     = 3;
    localparam int  CRPOC_ERR_REL     = 5;
    localparam int  CRPOC_ERR_MIN     = 2;
    localparam int  CRPOC_CNT_W       = 3;
    localparam int  CRPOC_CLK_MHZ     = 100;
    localparam int  CRPOC_WAKE_NS     = 100;
    localparam int  CRPOC_WAKE_CYC    = (CRPOC_WAKE_NS * CRPOC_CLK_MHZ + 999) / 1000;
    localparam int  CRPOC_SETTLE_NS   = 200;
    localparam int  CRPOC_SETTLE_CYC  = (CRPOC_SETTLE_NS * CRPOC_CLK_MHZ + 999) / 1000;
    localparam int  CRPOC_TMR_W       = 8;
    localparam int  CRPOC_CW_ADDR_LSB = 0;
    localparam int  CRPOC_CW_DATA_LSB = 4;
    localparam int  CRPOC_CW_FLOAT    = 0;
endpackage

// file: src/crpoc_if.sv
// crpoc_if: pins between the memory controller and the registering driver
// assumes the testbench resolves the open-drain error wire from its enable
`timescale 1ns/1ps
interface crpoc_if;
    import crpoc_pkg::*;
    logic [CRPOC_AC_W-1:0]  addr_cmd_in;
    logic                   parity_bit_in;
    logic [CRPOC_CS_W-1:0]  chip_select_in_n;
    logic [CRPOC_CKE_W-1:0] clock_enable_in;
    logic [CRPOC_ODT_W-1:0] termination_ctl_in;
    logic                   cw_access;
    logic                   clock_stopped;
    logic                   parity_error_out_n;
    logic                   parity_error_oe;
    logic                   parity_error_in_n;
    modport device (
        input  addr_cmd_in, parity_bit_in, chip_select_in_n, clock_enable_in, termination_ctl_in,
        input  cw_access, clock_stopped, parity_error_in_n,
        output parity_error_out_n, parity_error_oe
    );
    modport controller (
        output addr_cmd_in, parity_bit_in, chip_select_in_n, clock_enable_in, termination_ctl_in,
        output cw_access, clock_stopped,
        input  parity_error_in_n
    );
endinterface

// file: src/crpoc_device.sv
// crpoc_device: parity checker and output state control of the registering driver
// assumes controller obeys its pin rules; error wire is resolved outside via the enable
`timescale 1ns/1ps
module crpoc_device
    import crpoc_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   resetn,
    // controller side
    crpoc_if.device                     ctl,
    // module side outputs
    output logic [CRPOC_AC_W-1:0]       addr_cmd_out,
    output logic                        addr_cmd_oe,
    output logic [CRPOC_CS_W-1:0]       chip_select_out_n,
    output logic                        chip_select_oe,
    output logic [CRPOC_CKE_W-1:0]      clock_enable_out_a,
    output logic [CRPOC_CKE_W-1:0]      clock_enable_out_b,
    output logic [CRPOC_ODT_W-1:0]      termination_ctl_out,
    output logic                        termination_oe,
    output logic                        memory_clock_en,
    output logic                        feedback_clock_out,
    output logic                        input_bus_termination,
    output logic [3:0]                  cw_addr_out,
    output logic [3:0]                  cw_data_out,
    output logic                        float_option
);
    // stage 1 holds data waiting for its parity bit
    logic [CRPOC_AC_W-1:0]  ac_r;
    logic                   sel_r;
    logic                   cw_r;
    logic                   started_r;
    logic [2:0]             err_pipe_r;
    logic [CRPOC_CNT_W-1:0] err_cnt_r;
    logic [CRPOC_CNT_W-1:0] err_cnt_nxt;
    logic                   err_low_r;
    logic [3:0]             cw_addr_r;
    logic [3:0]             cw_data_r;
    logic                   fb_r;
    logic [CRPOC_CS_W-1:0]  cs_r;
    logic [CRPOC_AC_W-1:0]  aco_r;
    logic [CRPOC_CKE_W-1:0] cke_r;
    logic [CRPOC_ODT_W-1:0] odt_r;
    logic                   gate_r;
    logic                   run_r;

    wire any_sel    = ~&ctl.chip_select_in_n;
    wire par_odd    = ^{ac_r, ctl.parity_bit_in};
    wire par_err    = sel_r & par_odd;
    wire cw_ok      = cw_r & sel_r & ~par_odd;
    wire floated    = float_option & ~any_sel;
    wire drive_on   = run_r & ~ctl.clock_stopped;

    // release count from the third edge: error held through cycle n+4, high-z at n+5
    always_comb begin
        err_cnt_nxt = err_cnt_r;
        if (err_pipe_r[1]) begin
            err_cnt_nxt = CRPOC_CNT_W'(CRPOC_ERR_REL - CRPOC_ERR_LAT);
        end else if (err_cnt_r != '0) begin
            err_cnt_nxt = err_cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ac_r       <= '0;
            sel_r      <= 1'b0;
            cw_r       <= 1'b0;
            err_pipe_r <= '0;
            err_cnt_r  <= '0;
            err_low_r  <= 1'b0;
        end else if (!ctl.clock_stopped) begin
            ac_r       <= ctl.addr_cmd_in;
            sel_r      <= any_sel;
            cw_r       <= ctl.cw_access;
            err_pipe_r <= {err_pipe_r[1:0], par_err};
            err_cnt_r  <= err_cnt_nxt;
            err_low_r  <= (err_cnt_nxt != '0);
        end
    end

    // control words survive a stopped clock, cleared only by reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cw_addr_r    <= '0;
            cw_data_r    <= '0;
            float_option <= 1'b0;
        end else if (!ctl.clock_stopped && cw_ok) begin
            cw_addr_r <= ac_r[CRPOC_CW_ADDR_LSB +: 4];
            cw_data_r <= ac_r[CRPOC_CW_DATA_LSB +: 4];
            if (ac_r[CRPOC_CW_ADDR_LSB +: 4] == 4'h0) begin
                float_option <= ac_r[CRPOC_CW_DATA_LSB + CRPOC_CW_FLOAT];
            end
        end
    end

    // output stage
    always_ff @(posedge clk) begin
        if (!resetn) begin
            started_r <= 1'b0;
            run_r     <= 1'b0;
            cs_r      <= '1;
            aco_r     <= '0;
            cke_r     <= '0;
            odt_r     <= '0;
            gate_r    <= 1'b0;
            fb_r      <= 1'b0;
        end else begin
            started_r <= 1'b1;
            run_r     <= 1'b1;
            gate_r    <= ~floated;
            fb_r      <= drive_on ? ~fb_r : 1'b0;
            if (ctl.clock_stopped) begin
                cke_r <= '0;
            end else begin
                cs_r  <= started_r ? ctl.chip_select_in_n : '1;
                aco_r <= ctl.addr_cmd_in;
                cke_r <= started_r ? ctl.clock_enable_in : '0;
                odt_r <= ctl.termination_ctl_in;
            end
        end
    end

    always_comb begin
        ctl.parity_error_out_n = 1'b0;
        ctl.parity_error_oe    = err_low_r;
    end

    assign addr_cmd_out          = aco_r;
    assign addr_cmd_oe           = drive_on & gate_r;
    assign chip_select_out_n     = cs_r;
    assign chip_select_oe        = drive_on;
    assign clock_enable_out_a    = cke_r;
    assign clock_enable_out_b    = cke_r;
    assign termination_ctl_out   = odt_r;
    assign termination_oe        = drive_on;
    assign memory_clock_en       = drive_on;
    assign feedback_clock_out    = fb_r;
    assign input_bus_termination = run_r;
    assign cw_addr_out           = cw_addr_r;
    assign cw_data_out           = cw_data_r;
endmodule

// file: src/crpoc_controller.sv
// crpoc_controller: memory controller end that drives commands with delayed parity
// assumes user requests are one per cycle; pin-facing values come from flip-flops
`timescale 1ns/1ps
module crpoc_controller
    import crpoc_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   resetn,
    // user side
    input  wire logic                   cmd_valid,
    input  wire logic [CRPOC_AC_W-1:0]  cmd_addr_cmd,
    input  wire logic [CRPOC_CS_W-1:0]  cmd_select_n,
    input  wire logic                   cmd_cw,
    input  wire logic                   cmd_bad_parity,
    input  wire logic [CRPOC_CKE_W-1:0] user_cke,
    input  wire logic [CRPOC_ODT_W-1:0] user_odt,
    input  wire logic                   stop_clock,
    output logic                        ready,
    output logic                        error_seen,
    // device side
    crpoc_if.controller                 ctl
);
    logic [CRPOC_AC_W-1:0]  ac_r;
    logic [CRPOC_CS_W-1:0]  cs_r;
    logic [CRPOC_CKE_W-1:0] cke_r;
    logic [CRPOC_ODT_W-1:0] odt_r;
    logic                   cw_r;
    logic                   par_r;
    // wrong-parity request rides with its data so the flip lands on the parity cycle
    logic                   bad_r;
    logic                   stop_r;
    logic [CRPOC_TMR_W-1:0] tmr_r;

    wire quiet  = stop_r | (tmr_r != '0);
    wire issue  = cmd_valid & ~quiet;
    wire [CRPOC_TMR_W-1:0] settle = CRPOC_TMR_W'(CRPOC_SETTLE_CYC);
    wire [CRPOC_TMR_W-1:0] wake   = CRPOC_TMR_W'(CRPOC_WAKE_CYC);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ac_r       <= '0;
            cs_r       <= '1;
            cke_r      <= '0;
            odt_r      <= '0;
            cw_r       <= 1'b0;
            par_r      <= 1'b0;
            bad_r      <= 1'b0;
            stop_r     <= 1'b0;
            tmr_r      <= settle;
            ready      <= 1'b0;
            error_seen <= 1'b0;
        end else begin
            stop_r     <= stop_clock;
            ready      <= ~quiet;
            error_seen <= ~ctl.parity_error_in_n;
            if (stop_r & ~stop_clock) begin
                tmr_r <= settle;
            end else if (tmr_r != '0) begin
                tmr_r <= tmr_r - 1'b1;
            end
            par_r <= (^ac_r) ^ bad_r;
            bad_r <= issue & cmd_bad_parity;
            odt_r <= user_odt;
            cke_r <= (quiet && (stop_r || tmr_r > settle - wake)) ? '0 : user_cke;
            cs_r  <= issue ? cmd_select_n : '1;
            cw_r  <= issue & cmd_cw;
            ac_r  <= issue ? cmd_addr_cmd : ac_r;
        end
    end

    assign ctl.addr_cmd_in        = ac_r;
    assign ctl.parity_bit_in      = par_r;
    assign ctl.chip_select_in_n   = cs_r;
    assign ctl.clock_enable_in    = cke_r;
    assign ctl.termination_ctl_in = odt_r;
    assign ctl.cw_access          = cw_r;
    assign ctl.clock_stopped      = stop_r;
endmodule

// file: bench/crpoc_checker_sva.sv
// crpoc_checker: timing checks on the pins between controller and device
// assumes it sits beside the interface and sees its signals as plain inputs
`timescale 1ns/1ps
module crpoc_checker
    import crpoc_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   resetn,
    // interface pins
    input  wire logic [CRPOC_AC_W-1:0]  addr_cmd_in,
    input  wire logic                   parity_bit_in,
    input  wire logic [CRPOC_CS_W-1:0]  chip_select_in_n,
    input  wire logic [CRPOC_CKE_W-1:0] clock_enable_in,
    input  wire logic                   clock_stopped,
    input  wire logic                   parity_error_oe
);
    logic sel_r;
    logic ones_r;
    // parity bit arrives one cycle late, so the data side is held back one edge
    wire  err_ev = sel_r & (ones_r ^ parity_bit_in) & !clock_stopped;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sel_r  <= 1'b0;
            ones_r <= 1'b0;
        end else begin
            sel_r  <= !(&chip_select_in_n) & !clock_stopped;
            ones_r <= ^addr_cmd_in;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_err_low;     err_ev |-> ##3 parity_error_oe [*2]; endproperty
    property p_err_rel;     err_ev ##1 !err_ev ##1 !err_ev |-> ##3 !parity_error_oe; endproperty
    property p_err_cause;   $rose(parity_error_oe) |-> $past(err_ev, 3); endproperty
    property p_err_min;     $fell(parity_error_oe) |-> $past(parity_error_oe, 2); endproperty
    property p_rst;         disable iff (1'b0) !resetn |=> !parity_error_oe; endproperty
    property p_stop_quiet;  clock_stopped [*6] |-> !parity_error_oe; endproperty
    property p_wake;        $fell(clock_stopped) |-> (&chip_select_in_n) && clock_enable_in == 2'h0; endproperty
    property p_rls;         $rose(resetn) |-> (&chip_select_in_n) [*8]; endproperty
    a_err_low: assert property (p_err_low)
        else $error("error output not pulled low on time");
    a_err_rel: assert property (p_err_rel)
        else $error("error output not released on time");
    a_err_cause: assert property (p_err_cause)
        else $error("error output pulled low without a selected mismatch");
    a_err_min: assert property (p_err_min)
        else $error("error output low for less than two cycles");
    a_rst: assert property (p_rst)
        else $error("error output pulled low during reset");
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("error output active while clock stopped");
    a_wake: assert property (p_wake)
        else $error("selects or clock enables wrong at clock restart");
    a_rls: assert property (p_rls)
        else $error("select inputs not held high after reset release");
    c_err: cover property (err_ev);
    c_desel: cover property (!sel_r && (ones_r ^ parity_bit_in));
    c_wake: cover property ($fell(clock_stopped));
endmodule

// file: bench/cmd_register_parity_and_output_control_tb.sv
// cmd_register_parity_and_output_control_tb: controller and device joined, user side driven
// assumes package, interface and both ends are compiled first
`timescale 1ns/1ps
module cmd_register_parity_and_output_control_tb
    import crpoc_pkg::*;
;
    logic clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, cmd_cw = 1'b0, cmd_bad_parity = 1'b0, stop_clock = 1'b0;
    logic [CRPOC_AC_W-1:0]  cmd_addr_cmd = 24'h0;
    logic [CRPOC_CS_W-1:0]  cmd_select_n = 4'hf, chip_select_out_n;
    logic [CRPOC_CKE_W-1:0] user_cke = 2'h0, clock_enable_out_a, clock_enable_out_b;
    logic [CRPOC_ODT_W-1:0] user_odt = 2'h0, termination_ctl_out;
    logic [3:0]             cw_data_out, cw_addr_out;
    logic ready, addr_cmd_oe, chip_select_oe, input_bus_termination, float_option, memory_clock_en;
    int   fails = 0, samples_checked = 0;
    always #5 clk = ~clk;
    crpoc_if ifc();
    assign ifc.parity_error_in_n = ifc.parity_error_oe ? ifc.parity_error_out_n : 1'b1;
    crpoc_controller i_crpoc_controller (.clk, .resetn, .cmd_valid, .cmd_addr_cmd, .cmd_select_n, .cmd_cw,
        .cmd_bad_parity, .user_cke, .user_odt, .stop_clock, .ready, .error_seen(), .ctl(ifc.controller));
    crpoc_device i_crpoc_device (.clk, .resetn, .ctl(ifc.device), .addr_cmd_out(), .addr_cmd_oe, .chip_select_out_n,
        .chip_select_oe, .clock_enable_out_a, .clock_enable_out_b, .termination_ctl_out, .termination_oe(),
        .memory_clock_en, .feedback_clock_out(), .input_bus_termination, .cw_addr_out, .cw_data_out, .float_option);
    crpoc_checker i_crpoc_checker (.clk, .resetn, .addr_cmd_in(ifc.addr_cmd_in), .parity_bit_in(ifc.parity_bit_in),
        .chip_select_in_n(ifc.chip_select_in_n), .clock_enable_in(ifc.clock_enable_in),
        .clock_stopped(ifc.clock_stopped), .parity_error_oe(ifc.parity_error_oe));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        if (fails == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wait_ready;
        int i;
        for (i = 0; i < 100 && ready !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 100) begin
            fails++;
            complete_run();
        end
    endtask
    // four back-to-back commands; the error wire is sampled after every edge but the first
    task automatic errs(input logic [3:0] bad, input logic [3:0] desel);
        logic [13:0] exp, obs;
        exp = 14'h0;
        obs = 14'h0;
        for (int k = 0; k < 4; k++) if (bad[k] && !desel[k]) exp[k+4 +: 2] = 2'h3;
        wait_ready();
        for (int j = 0; j < 15; j++) begin
            @(posedge clk);
            cmd_valid      <= j < 4;
            cmd_bad_parity <= j < 4 && bad[j[1:0]];
            cmd_select_n   <= desel[j[1:0]] ? 4'hf : 4'he;
            cmd_addr_cmd   <= 24'h00a5c3 << j;
            user_cke       <= j[1:0];
            user_odt       <= j[2:1];
            #1;
            if (j > 0) obs[j-1] = ~ifc.parity_error_in_n;
        end
        chk("error wire pattern", {18'h0, exp}, {18'h0, obs});
    endtask
    task automatic ctlword(input logic [3:0] data, input logic bad, input logic [3:0] expd);
        wait_ready();
        @(posedge clk);
        cmd_valid      <= 1'b1;
        cmd_cw         <= 1'b1;
        cmd_bad_parity <= bad;
        cmd_select_n   <= 4'he;
        cmd_addr_cmd   <= {16'h0, data, 4'h0};
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_cw    <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk("control data", {28'h0, expd}, {28'h0, cw_data_out});
        chk("control address", 32'h0, {28'h0, cw_addr_out});
        chk("gated enable while deselected", {31'h0, !expd[0]}, {31'h0, addr_cmd_oe});
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge clk);
        #1;
        chk("cke in reset", 32'h0, {30'h0, clock_enable_out_a});
        chk("select enable in reset", 32'h0, {31'h0, chip_select_oe});
        chk("bus termination in reset", 32'h0, {31'h0, input_bus_termination});
        chk("termination in reset", 32'h0, {30'h0, termination_ctl_out});
        chk("error wire in reset", 32'h1, {31'h0, ifc.parity_error_in_n});
        @(posedge clk) resetn <= 1'b1;
        @(posedge clk);
        #1;
        chk("select out after release", 32'hf, {28'h0, chip_select_out_n});
        chk("cke out after release", 32'h0, {30'h0, clock_enable_out_b});
        chk("memory clocks after release", 32'h1, {31'h0, memory_clock_en});
        errs(4'h1, 4'h0);
        errs(4'h3, 4'h0);
        errs(4'h5, 4'h0);
        errs(4'h9, 4'h0);
        errs(4'h3, 4'h2);
        errs(4'h0, 4'h0);
        ctlword(4'h1, 1'b0, 4'h1);
        ctlword(4'h0, 1'b1, 4'h1);
        @(posedge clk);
        stop_clock <= 1'b1;
        user_cke   <= 2'h0;
        repeat (6) @(posedge clk);
        #1;
        chk("cke while stopped", 32'h0, {30'h0, clock_enable_out_a});
        chk("address enable while stopped", 32'h0, {31'h0, addr_cmd_oe});
        chk("memory clocks while stopped", 32'h0, {31'h0, memory_clock_en});
        @(posedge clk) stop_clock <= 1'b0;
        wait_ready();
        chk("float kept over stop", 32'h1, {31'h0, float_option});
        errs(4'h1, 4'h0);
        wait_ready();
        @(posedge clk);
        cmd_valid      <= 1'b1;
        cmd_bad_parity <= 1'b1;
        cmd_select_n   <= 4'he;
        @(posedge clk) cmd_valid <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b0;
        #1;
        chk("error wire before reset", 32'h0, {31'h0, ifc.parity_error_in_n});
        @(posedge clk);
        #1;
        chk("error ends at reset", 32'h1, {31'h0, ifc.parity_error_in_n});
        chk("control word cleared", 32'h0, {31'h0, float_option});
        repeat (9) @(posedge clk);
        resetn <= 1'b1;
        errs(4'h1, 4'h0);
        complete_run();
    end
endmodule
